//--- verilog/cem_calib_map_regs.vh
// constants for the calibration memory map and field decoder
// assumes a 64-word memory of 5-bit words (4 data bits + parity)
`ifndef CEM_CALIB_MAP_REGS_VH
`define CEM_CALIB_MAP_REGS_VH

// ==================================================================
// geometry
`define CEM_ADDR_W          6
`define CEM_CAL_WORDS       6'h20
`define CEM_LAST_CAL_WORD   5'h1F
`define CEM_PARITY_BIT      4
`define CEM_PARITY_ODD      1'b0
`define CEM_WORD_RESET      4'h0

// ==================================================================
// word offsets of the calibration fields
`define CEM_GAIN_TEMP_REF           5'h00
`define CEM_OSCILLATOR_TRIM         5'h03
`define CEM_GAIN_COEF_SECOND_ORDER  5'h04
`define CEM_INPUT_SWAP_COARSE_GAIN  5'h07
`define CEM_GAIN_COEF_FIRST_ORDER   5'h08
`define CEM_COARSE_OFFSET_LOW       5'h0B
`define CEM_GAIN_COEF_ZERO_ORDER    5'h0C
`define CEM_CLAMP_EN_COARSE_OFF_HI  5'h0F
`define CEM_OFFSET_TEMP_REF         5'h10
`define CEM_CLAMP_LEVEL_LOW_WORD    5'h13
`define CEM_OFFSET_COEF_SECOND      5'h14
`define CEM_TEMP_SOURCE_CLAMP_HIGH  5'h17
`define CEM_OFFSET_COEF_FIRST       5'h18
`define CEM_TEMP_SENSOR_OFFSET_TRIM 5'h1B
`define CEM_OFFSET_COEF_ZERO        5'h1C
`define CEM_TEMP_SENSOR_GAIN_TRIM   5'h1F

// ==================================================================
// field bit positions inside a word
`define CEM_INPUT_SWAP_BIT   0
`define CEM_CLAMP_EN_BIT     0
`define CEM_TEMP_SOURCE_BIT  1
`define CEM_TMP_OFF0_BIT     0

// ==================================================================
// clamp levels in per-mille of output
`define CEM_CLAMP_LOW_BASE   10'h028
`define CEM_CLAMP_HIGH_BASE  10'h35C
`define CEM_CLAMP_SPAN       10'h064
`define CEM_CLAMP_STEPS      10'h007

`endif

//--- verilog/cem_calib_map.v
// calibration memory loader and field decoder of the bridge conditioner
// assumes a triple-copy calibration memory with one-cycle synchronous read,
// and a programmer command decoder on the same ref_clk issuing word writes
`include "cem_calib_map_regs.vh"
`default_nettype none

module cem_calib_map (
  input  wire        ref_clk,
  input  wire        rst_b,
  // triple-copy memory read port
  // copies due one cycle after strobe
  // parity in bit 4, data in bits 3:0
  output reg  [5:0]  eeAddr_ff,
  output reg         eeRdEn_ff,
  input  wire [4:0]  eeCopyA,
  input  wire [4:0]  eeCopyB,
  input  wire [4:0]  eeCopyC,

  // word writes from the programmer command decoder
  // one-cycle strobe, dropped during load
  input  wire        progWrEn,
  input  wire [5:0]  progWrAddr,
  input  wire [7:0]  progWrData,

  // status
  // fault flags stay set until reset
  output reg         pathEnable_ff,
  output reg         parityErr_ff,
  output reg         voteMismatch_ff,

  // decoded fields
  // levels, held between writes
  output reg  [3:0]  osc_trim_code_ff,
  output reg  [11:0] gainTempRef_ff,
  output reg  [11:0] gain_coef_second_ff,
  output reg         input_swap_ff,
  output reg  [2:0]  coarse_gain_code_ff,
  output reg  [11:0] gain_coef_first_ff,
  output reg  [6:0]  coarse_offset_code_ff,
  output reg  [9:0]  gain_coef_zero_ff,
  output reg         clampEnable_ff,
  output reg  [11:0] offsetTempRef_ff,
  output reg  [5:0]  clampCode_ff,
  output reg  [9:0]  clampLowPermille_ff,
  output reg  [9:0]  clampHighPermille_ff,
  output reg  [11:0] offset_coef_second_ff,
  output reg  [11:0] offset_coef_first_ff,
  output reg  [9:0]  offset_coef_zero_ff,
  output reg  [4:0]  temp_sensor_offset_trim_ff,
  output reg         temp_sensor_source_ff,
  output reg  [2:0]  temp_sensor_gain_trim_ff
);

  // ================================================================
  // state codes of the loader
  localparam [1:0] ST_LOAD  = 2'h0;  // issuing reads
  localparam [1:0] ST_DRAIN = 2'h1;  // last read in flight
  localparam [1:0] ST_RUN   = 2'h2;  // fields valid, path on
  // no return to load without reset:
  // the copy is not refreshed on demand
  // unused code 3 restarts the load

  // ================================================================
  // declarations
  reg  [1:0]  state_ff;                // loader state
  reg  [1:0]  nxt_state;
  reg  [5:0]  nxt_eeAddr;
  reg         nxt_eeRdEn;
  reg         rdPend_ff;               // a read answer arrives this cycle
  reg  [4:0]  rdWord_ff;               // word index of the pending answer
  reg  [3:0]  calWord_ff [0:31];       // working copy of the calibration words
  wire [4:0]  voted;                   // bitwise majority of the copies
  wire        votedParOk;
  wire        copiesDiffer;
  wire        progAccept;
  wire [6:0]  clampLowIdx;
  wire [6:0]  clampHighIdx;
  integer     i;
  // 32 words: plain flops, no read delay
  // and every field readable at once

  // ================================================================
  // majority vote and parity check
  // vote first, then check parity, so a single bad copy is masked
  // two copies upset in one bit beat
  // the vote; parity then flags it
  // parity is even over data bits
  // the flags only look at the load
  assign voted        = (eeCopyA & eeCopyB) | (eeCopyA & eeCopyC)
                        | (eeCopyB & eeCopyC);
  assign votedParOk   = ((^voted[3:0]) ^ `CEM_PARITY_ODD)
                        == voted[`CEM_PARITY_BIT];
  assign copiesDiffer = (eeCopyA != eeCopyB) | (eeCopyA != eeCopyC);

  // programmer writes: only calibration words, top three bits zero
  // writes above word 31 are customer or reserved space, no effect
  // writes during load are dropped so a
  // stale word cannot overtake the burst
  // word 3 accepted: the trim is guarded
  // by the programmer, not here
  assign progAccept = progWrEn & (state_ff == ST_RUN)
                      & (progWrAddr < `CEM_CAL_WORDS)
                      & (progWrData[7:5] == 3'h0);

  // ================================================================
  // loader next-state logic
  // edge 1 after reset: strobe up, word 0
  // edge 2: word 0 read, address 1
  // edges 3 to 32: one word per cycle
  // edge 33: word 31 read, strobe down
  // edge 34: word 31 in the copy
  // edge 35: run, path and fields valid
  // back to back: whole load near 3.5 us
  // a mid-run reset restarts at word 0
  // no retry on a fault: the flag rises,
  // the voted word is still used, so the
  // path comes up with one bad copy
  // pathEnable_ff follows nxt_state so it
  // rises with the fields
  always @* begin
    nxt_state  = state_ff;
    nxt_eeAddr = eeAddr_ff;
    nxt_eeRdEn = 1'b0;
    case (state_ff)
      ST_LOAD: begin
        // one read per cycle, words 0 to 31 in order
        nxt_eeRdEn = 1'b1;
        if (eeRdEn_ff) begin
          if (eeAddr_ff[4:0] == `CEM_LAST_CAL_WORD) begin
            nxt_eeRdEn = 1'b0;
            nxt_state  = ST_DRAIN;
          end else begin
            nxt_eeAddr = eeAddr_ff + 6'h01;
          end
        end
      end
      ST_DRAIN: begin
        // wait until the last answer has landed
        if (!rdPend_ff && !eeRdEn_ff) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        // held until reset;
        // only writes change fields here
        nxt_state = ST_RUN;
      end
      default: begin
        // unused code: restart the load
        nxt_state = ST_LOAD;
      end
    endcase
  end

  // ================================================================
  // loader registers and working copy
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff        <= ST_LOAD;
      eeAddr_ff       <= 6'h00;
      eeRdEn_ff       <= 1'b0;
      rdPend_ff       <= 1'b0;
      rdWord_ff       <= 5'h00;
      pathEnable_ff   <= 1'b0;
      parityErr_ff    <= 1'b0;
      voteMismatch_ff <= 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
        calWord_ff[i] <= `CEM_WORD_RESET;
      end
    end else begin
      state_ff      <= nxt_state;
      eeAddr_ff     <= nxt_eeAddr;
      eeRdEn_ff     <= nxt_eeRdEn;
      // answer lands a cycle after strobe
      // rdWord_ff names its word
      rdPend_ff     <= eeRdEn_ff;
      rdWord_ff     <= eeAddr_ff[4:0];
      // path stays off until every word has been copied
      pathEnable_ff <= (nxt_state == ST_RUN);
      if (rdPend_ff) begin
        calWord_ff[rdWord_ff] <= voted[3:0];
        // sticky diagnosis flags, cleared only by reset
        if (!votedParOk) begin
          parityErr_ff <= 1'b1;
        end
        if (copiesDiffer) begin
          voteMismatch_ff <= 1'b1;
        end
      end else if (progAccept) begin
        // never meets an answer: run only
        // live update so the programmer sees the effect at once
        calWord_ff[progWrAddr[4:0]] <= progWrData[3:0];
      end
    end
  end

  // ================================================================
  // clamp level tables, linear over eight steps, per-mille
  // low:  40 54 68 82 97 111 125 140
  // high: 860 874 888 902 917 931 945 960
  // floor loses under one per-mille;
  // a table is exact but costs gates
  // the raw code is passed on unscaled
  assign clampLowIdx  = {4'h0, calWord_ff[`CEM_CLAMP_LEVEL_LOW_WORD][1]
                        , calWord_ff[`CEM_CLAMP_LEVEL_LOW_WORD][2]
                        , calWord_ff[`CEM_CLAMP_LEVEL_LOW_WORD][3]};
  assign clampHighIdx = {4'h0, calWord_ff[`CEM_TEMP_SOURCE_CLAMP_HIGH][2]
                        , calWord_ff[`CEM_TEMP_SOURCE_CLAMP_HIGH][3]
                        , calWord_ff[`CEM_CLAMP_LEVEL_LOW_WORD][0]};

  // scale a 3-bit step to the 100 per-mille span, rounded down
  function [9:0] clamp_level;
    input [9:0] base;
    input [6:0] idx;
    reg   [19:0] prod;
    begin
      prod        = {13'h0000, idx} * {10'h000, `CEM_CLAMP_SPAN};
      clamp_level = base + prod[9:0] / `CEM_CLAMP_STEPS;
    end
  endfunction

  // ================================================================
  // field decoder: every output registered straight from the copy
  // word map, data bits 0..3 per word:
  //   0-2   gain temperature reference
  //   3     oscillator trim, msb in bit 0
  //   4-6   second-order gain coefficient
  //   7     swap; coarse gain, msb in bit 1
  //   8-10  first-order gain coefficient
  //   11    coarse offset 3..0, msb in bit 0
  //   12-14 zero-order gain, 10 bits used
  //   15    clamp on; coarse offset 6..4
  //   16-18 offset temperature reference
  //   19    clamp code 3..0, msb in bit 0
  //   20-22 second-order offset coefficient
  //   23    sensor offset lsb, source, clamp 5..4
  //   24-26 first-order offset coefficient
  //   27    sensor offset 4..1, msb in bit 0
  //   28-30 zero-order offset, 10 bits used
  //   31    sensor gain trim in bits 1 to 3
  // fields follow their words one clock
  // after the word changes
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      // fields zero until loaded; clamp
      // levels rest at band bottoms
      // so no clamp acts on a bare zero
      osc_trim_code_ff           <= 4'h0;
      gainTempRef_ff             <= 12'h000;
      gain_coef_second_ff        <= 12'h000;
      input_swap_ff              <= 1'b0;
      coarse_gain_code_ff        <= 3'h0;
      gain_coef_first_ff         <= 12'h000;
      coarse_offset_code_ff      <= 7'h00;
      gain_coef_zero_ff          <= 10'h000;
      clampEnable_ff             <= 1'b0;
      offsetTempRef_ff           <= 12'h000;
      clampCode_ff               <= 6'h00;
      clampLowPermille_ff        <= `CEM_CLAMP_LOW_BASE;
      clampHighPermille_ff       <= `CEM_CLAMP_HIGH_BASE;
      offset_coef_second_ff      <= 12'h000;
      offset_coef_first_ff       <= 12'h000;
      offset_coef_zero_ff        <= 10'h000;
      temp_sensor_offset_trim_ff <= 5'h00;
      temp_sensor_source_ff      <= 1'b0;
      temp_sensor_gain_trim_ff   <= 3'h0;
    end else begin
      // word 3 stores the trim msb first in bit 0
      osc_trim_code_ff <= {calWord_ff[`CEM_OSCILLATOR_TRIM][0],
                           calWord_ff[`CEM_OSCILLATOR_TRIM][1],
                           calWord_ff[`CEM_OSCILLATOR_TRIM][2],
                           calWord_ff[`CEM_OSCILLATOR_TRIM][3]};

      // references: top word holds bits 11:8
      gainTempRef_ff <= {calWord_ff[`CEM_GAIN_TEMP_REF + 5'h02],
                         calWord_ff[`CEM_GAIN_TEMP_REF + 5'h01],
                         calWord_ff[`CEM_GAIN_TEMP_REF]};
      // coefficients: low word holds bits 3:0, bit 11 is the sign
      gain_coef_second_ff <= {calWord_ff[`CEM_GAIN_COEF_SECOND_ORDER + 5'h02],
                              calWord_ff[`CEM_GAIN_COEF_SECOND_ORDER + 5'h01],
                              calWord_ff[`CEM_GAIN_COEF_SECOND_ORDER]};

      // set: the bridge inputs are exchanged
      input_swap_ff <= calWord_ff[`CEM_INPUT_SWAP_COARSE_GAIN]
                       [`CEM_INPUT_SWAP_BIT];
      coarse_gain_code_ff <= {calWord_ff[`CEM_INPUT_SWAP_COARSE_GAIN][1],
                              calWord_ff[`CEM_INPUT_SWAP_COARSE_GAIN][2],
                              calWord_ff[`CEM_INPUT_SWAP_COARSE_GAIN][3]};

      // packed like the second-order term
      gain_coef_first_ff <= {calWord_ff[`CEM_GAIN_COEF_FIRST_ORDER + 5'h02],
                             calWord_ff[`CEM_GAIN_COEF_FIRST_ORDER + 5'h01],
                             calWord_ff[`CEM_GAIN_COEF_FIRST_ORDER]};
      // coarse offset: bits 6:4 in word 15, bits 3:0 in word 11
      coarse_offset_code_ff <= {calWord_ff[`CEM_CLAMP_EN_COARSE_OFF_HI][1],
                                calWord_ff[`CEM_CLAMP_EN_COARSE_OFF_HI][2],
                                calWord_ff[`CEM_CLAMP_EN_COARSE_OFF_HI][3],
                                calWord_ff[`CEM_COARSE_OFFSET_LOW][0],
                                calWord_ff[`CEM_COARSE_OFFSET_LOW][1],
                                calWord_ff[`CEM_COARSE_OFFSET_LOW][2],
                                calWord_ff[`CEM_COARSE_OFFSET_LOW][3]};
      // top two stored bits ignored even if written nonzero
      gain_coef_zero_ff <= {calWord_ff[`CEM_GAIN_COEF_ZERO_ORDER + 5'h02][1:0],
                            calWord_ff[`CEM_GAIN_COEF_ZERO_ORDER + 5'h01],
                            calWord_ff[`CEM_GAIN_COEF_ZERO_ORDER]};

      // zero leaves the output unclamped
      clampEnable_ff <= calWord_ff[`CEM_CLAMP_EN_COARSE_OFF_HI]
                        [`CEM_CLAMP_EN_BIT];

      // packed like the gain reference
      offsetTempRef_ff <= {calWord_ff[`CEM_OFFSET_TEMP_REF + 5'h02],
                           calWord_ff[`CEM_OFFSET_TEMP_REF + 5'h01],
                           calWord_ff[`CEM_OFFSET_TEMP_REF]};

      // raw code kept beside the levels
      clampCode_ff <= {clampHighIdx[2:0], clampLowIdx[2:0]};
      clampLowPermille_ff  <= clamp_level(`CEM_CLAMP_LOW_BASE, clampLowIdx);
      clampHighPermille_ff <= clamp_level(`CEM_CLAMP_HIGH_BASE, clampHighIdx);

      // offset terms, bit 11 is the sign
      offset_coef_second_ff <= {calWord_ff[`CEM_OFFSET_COEF_SECOND + 5'h02],
                                calWord_ff[`CEM_OFFSET_COEF_SECOND + 5'h01],
                                calWord_ff[`CEM_OFFSET_COEF_SECOND]};
      offset_coef_first_ff <= {calWord_ff[`CEM_OFFSET_COEF_FIRST + 5'h02],
                               calWord_ff[`CEM_OFFSET_COEF_FIRST + 5'h01],
                               calWord_ff[`CEM_OFFSET_COEF_FIRST]};

      // top two bits ignored, as for gain
      offset_coef_zero_ff <= {calWord_ff[`CEM_OFFSET_COEF_ZERO + 5'h02][1:0],
                              calWord_ff[`CEM_OFFSET_COEF_ZERO + 5'h01],
                              calWord_ff[`CEM_OFFSET_COEF_ZERO]};
      // sensor offset: bits 4:1 in word 27 msb first, bit 0 in word 23
      temp_sensor_offset_trim_ff <= {calWord_ff[`CEM_TEMP_SENSOR_OFFSET_TRIM][0],
                                     calWord_ff[`CEM_TEMP_SENSOR_OFFSET_TRIM][1],
                                     calWord_ff[`CEM_TEMP_SENSOR_OFFSET_TRIM][2],
                                     calWord_ff[`CEM_TEMP_SENSOR_OFFSET_TRIM][3],
                                     calWord_ff[`CEM_TEMP_SOURCE_CLAMP_HIGH]
                                               [`CEM_TMP_OFF0_BIT]};

      // one picks the internal sensor
      temp_sensor_source_ff <= calWord_ff[`CEM_TEMP_SOURCE_CLAMP_HIGH]
                               [`CEM_TEMP_SOURCE_BIT];

      // bit 0 of word 31 is spare
      temp_sensor_gain_trim_ff <= {calWord_ff[`CEM_TEMP_SENSOR_GAIN_TRIM][1],
                                   calWord_ff[`CEM_TEMP_SENSOR_GAIN_TRIM][2],
                                   calWord_ff[`CEM_TEMP_SENSOR_GAIN_TRIM][3]};
    end
  end

endmodule

`default_nettype wire

//--- tb/cem_calib_map_asserts.sv
// checker: load burst, write acceptance and clamp mapping of the decoder
// assumes it is bound onto cem_calib_map, one ref_clk domain, async rst_b
`default_nettype none
module cem_calib_map_checker (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic [5:0] eeAddr_ff,
  input wire logic       eeRdEn_ff,
  input wire logic       progWrEn,
  input wire logic [5:0] progWrAddr,
  input wire logic [7:0] progWrData,
  input wire logic       pathEnable_ff,
  input wire logic       parityErr_ff,
  input wire logic       voteMismatch_ff,
  input wire logic       input_swap_ff,
  input wire logic [9:0] gain_coef_zero_ff,
  input wire logic [5:0] clampCode_ff,
  input wire logic [9:0] clampLowPermille_ff,
  input wire logic [9:0] clampHighPermille_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ====================================================================
  // steps
  // accepted write; refused writes must leave every field alone
  sequence s_wr_ok(a);
    progWrEn && pathEnable_ff && progWrAddr == a && progWrData[7:5] == 3'h0;
  endsequence
  // last read of the load burst
  sequence s_last_rd;
    eeRdEn_ff && eeAddr_ff == 6'h1F;
  endsequence
  // ====================================================================
  // properties
  a_load_first_word: assert property ($rose(rst_b) |=> eeRdEn_ff && eeAddr_ff == 6'h00)
    else $error("load did not start at word zero");
  a_read_ascending: assert property (eeRdEn_ff && eeAddr_ff != 6'h1F |=>
    eeRdEn_ff && eeAddr_ff == $past(eeAddr_ff) + 6'h01) else $error("load burst broken");
  a_no_spare_read: assert property (eeRdEn_ff |-> eeAddr_ff <= 6'h1F)
    else $error("read beyond calibration words");
  a_path_after_load: assert property (s_last_rd |=> !eeRdEn_ff ##[1:3] pathEnable_ff)
    else $error("signal path not enabled after load");
  a_path_bus_idle: assert property (pathEnable_ff |-> !eeRdEn_ff)
    else $error("read while path enabled");
  a_swap_follows: assert property (s_wr_ok(6'h07) |=> ##1
    input_swap_ff == $past(progWrData[0], 2)) else $error("input swap not updated");
  a_zero_gain_top: assert property (s_wr_ok(6'h0E) |=> ##1
    gain_coef_zero_ff[9:8] == $past(progWrData[1:0], 2)) else $error("zero gain top bits");
  a_clamp_low_map: assert property ((pathEnable_ff && $stable(clampCode_ff)) [*3] |->
    clampLowPermille_ff == 10'h028 + clampCode_ff[2:0] * 10'h064 / 10'h007)
    else $error("low clamp level wrong");
  a_clamp_high_map: assert property ((pathEnable_ff && $stable(clampCode_ff)) [*3] |->
    clampHighPermille_ff == 10'h35C + clampCode_ff[5:3] * 10'h064 / 10'h007)
    else $error("high clamp level wrong");
  a_flags_sticky: assert property (!$fell(parityErr_ff) && !$fell(voteMismatch_ff))
    else $error("fault flag cleared without reset");
endmodule
bind cem_calib_map cem_calib_map_checker u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .eeAddr_ff(eeAddr_ff), .eeRdEn_ff(eeRdEn_ff),
  .progWrEn(progWrEn), .progWrAddr(progWrAddr), .progWrData(progWrData),
  .pathEnable_ff(pathEnable_ff), .parityErr_ff(parityErr_ff),
  .voteMismatch_ff(voteMismatch_ff), .input_swap_ff(input_swap_ff),
  .gain_coef_zero_ff(gain_coef_zero_ff), .clampCode_ff(clampCode_ff),
  .clampLowPermille_ff(clampLowPermille_ff), .clampHighPermille_ff(clampHighPermille_ff)
);
`default_nettype wire

//--- tb/cem_eeprom_model.sv
// triple-copy calibration memory with one-cycle synchronous read
// assumes the bench fills mem before releasing reset
`default_nettype none
module cem_eeprom_model (
  input  wire logic       ref_clk,
  input  wire logic       rdEn,
  input  wire logic [5:0] rdAddr,
  input  wire logic [1:0] faultMode,
  output var  logic [4:0] copyA,
  output var  logic [4:0] copyB,
  output var  logic [4:0] copyC
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] mem [64]; // upper half is customer and maker space
  wire  [3:0] d   = mem[rdAddr];
  wire  [3:0] e   = d ^ {3'h0, faultMode == 2'h1 && rdAddr == 6'h05}; // one copy outvoted
  wire        bad = faultMode == 2'h2 && rdAddr == 6'h05; // all copies fail parity
  // ====================================================================
  // read port: even parity per copy, faults on word 5 only when asked
  always @(posedge ref_clk) begin
    if (rdEn) begin
      copyA <= {^d ^ bad, d};
      copyB <= {^e ^ bad, e};
      copyC <= {^d ^ bad, d};
    end else begin
      // released bus: invert each idle cycle, so the last word shows again every second cycle
      {copyA, copyB, copyC} <= ~{copyA, copyB, copyC};
    end
  end
endmodule
`default_nettype wire

//--- tb/cem_calib_map_tb_top.sv
// self-checking bench for the calibration loader and field decoder
// assumes cem_calib_map, the memory model and the bound checker
`default_nettype none
module cem_calib_map_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam time TDRV = 5; // drive skew after each rising edge
  logic        ref_clk, rst_b, eeRdEn, progWrEn, pathEnable, parityErr, voteMismatch;
  logic        inputSwap, clampEn, tSrc;
  logic [1:0]  faultMode;
  logic [2:0]  coarseGain, tGain;
  logic [3:0]  oscTrim;
  logic [4:0]  copyA, copyB, copyC, tOff;
  logic [5:0]  eeAddr, progWrAddr, clampCode;
  logic [6:0]  coarseOff;
  logic [7:0]  progWrData;
  logic [9:0]  gainZero, offZero, clampLow, clampHigh;
  logic [11:0] gainTRef, gain2, gain1, offTRef, off2, off1;
  int          num_errors, comparisons, n;
  typedef struct packed {logic [5:0] a; logic [7:0] d; logic [3:0] sel; logic [11:0] x;} cem_row_t;
  // word 3 is factory data and is never written here
  cem_row_t rows [16] = '{'{6'h13, 8'h0E, 4'h0, 12'h08C}, '{6'h13, 8'h08, 4'h0, 12'h036},
    '{6'h13, 8'h02, 4'h0, 12'h061}, '{6'h13, 8'h00, 4'h0, 12'h028},
    '{6'h17, 8'h0C, 4'h1, 12'h3B1}, '{6'h13, 8'h01, 4'h1, 12'h3C0},
    '{6'h17, 8'h00, 4'h1, 12'h36A}, '{6'h17, 8'h02, 4'h2, 12'h001},
    '{6'h07, 8'h01, 4'h3, 12'h001}, '{6'h07, 8'h02, 4'h4, 12'h004},
    '{6'h07, 8'h08, 4'h4, 12'h001}, '{6'h0F, 8'h01, 4'h5, 12'h001},
    '{6'h0F, 8'h00, 4'h5, 12'h000}, '{6'h1F, 8'h02, 4'h6, 12'h004},
    '{6'h1B, 8'h01, 4'h7, 12'h010}, '{6'h0B, 8'h01, 4'h8, 12'h008}};
  cem_calib_map dut (.ref_clk(ref_clk), .rst_b(rst_b), .eeAddr_ff(eeAddr),
    .eeRdEn_ff(eeRdEn), .eeCopyA(copyA), .eeCopyB(copyB), .eeCopyC(copyC),
    .progWrEn(progWrEn), .progWrAddr(progWrAddr), .progWrData(progWrData),
    .pathEnable_ff(pathEnable), .parityErr_ff(parityErr), .voteMismatch_ff(voteMismatch),
    .osc_trim_code_ff(oscTrim), .gainTempRef_ff(gainTRef), .gain_coef_second_ff(gain2),
    .input_swap_ff(inputSwap), .coarse_gain_code_ff(coarseGain), .gain_coef_first_ff(gain1),
    .coarse_offset_code_ff(coarseOff), .gain_coef_zero_ff(gainZero), .clampEnable_ff(clampEn),
    .offsetTempRef_ff(offTRef), .clampCode_ff(clampCode), .clampLowPermille_ff(clampLow),
    .clampHighPermille_ff(clampHigh), .offset_coef_second_ff(off2),
    .offset_coef_first_ff(off1), .offset_coef_zero_ff(offZero),
    .temp_sensor_offset_trim_ff(tOff), .temp_sensor_source_ff(tSrc),
    .temp_sensor_gain_trim_ff(tGain));
  cem_eeprom_model mdl (.ref_clk(ref_clk), .rdEn(eeRdEn), .rdAddr(eeAddr),
    .faultMode(faultMode), .copyA(copyA), .copyB(copyB), .copyC(copyC));
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ====================================================================
  // helpers
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [11:0] fieldOf(input logic [3:0] sel);
    case (sel)
      4'h0: return 12'(clampLow);
      4'h1: return 12'(clampHigh);
      4'h2: return 12'(tSrc);
      4'h3: return 12'(inputSwap);
      4'h4: return 12'(coarseGain);
      4'h5: return 12'(clampEn);
      4'h6: return 12'(tGain);
      4'h7: return 12'(tOff);
      default: return 12'(coarseOff);
    endcase
  endfunction
  // one programmer write; returns once the decoded field has settled
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #TDRV {progWrEn, progWrAddr, progWrData} = {1'b1, a, d};
    @(posedge ref_clk);
    #TDRV progWrEn = 0;
    @(posedge ref_clk);
    #TDRV;
  endtask
  // every field worked out from the stored words
  task automatic check_all();
    logic [5:0] cc;
    cc = {mdl.mem[23][2], mdl.mem[23][3], mdl.mem[19][0], mdl.mem[19][1], mdl.mem[19][2],
          mdl.mem[19][3]};
    chk(12'(oscTrim), {mdl.mem[3][0], mdl.mem[3][1], mdl.mem[3][2], mdl.mem[3][3]});
    chk(gainTRef, {mdl.mem[2], mdl.mem[1], mdl.mem[0]});
    chk(gain2, {mdl.mem[6], mdl.mem[5], mdl.mem[4]});
    chk(12'({inputSwap, coarseGain}), 12'({mdl.mem[7][0], mdl.mem[7][1], mdl.mem[7][2],
        mdl.mem[7][3]}));
    chk(gain1, {mdl.mem[10], mdl.mem[9], mdl.mem[8]});
    chk(12'(coarseOff), 12'({mdl.mem[15][1], mdl.mem[15][2], mdl.mem[15][3], mdl.mem[11][0],
        mdl.mem[11][1], mdl.mem[11][2], mdl.mem[11][3]}));
    chk(12'(gainZero), {2'h0, mdl.mem[14][1:0], mdl.mem[13], mdl.mem[12]});
    chk(12'(clampEn), 12'(mdl.mem[15][0]));
    chk(offTRef, {mdl.mem[18], mdl.mem[17], mdl.mem[16]});
    chk(12'(clampCode), 12'(cc));
    chk(12'(clampLow), 12'h028 + cc[2:0] * 12'h064 / 12'h007);
    chk(12'(clampHigh), 12'h35C + cc[5:3] * 12'h064 / 12'h007);
    chk(off2, {mdl.mem[22], mdl.mem[21], mdl.mem[20]});
    chk(off1, {mdl.mem[26], mdl.mem[25], mdl.mem[24]});
    chk(12'(offZero), {2'h0, mdl.mem[30][1:0], mdl.mem[29], mdl.mem[28]});
    chk(12'(tOff), 12'({mdl.mem[27][0], mdl.mem[27][1], mdl.mem[27][2], mdl.mem[27][3],
        mdl.mem[23][0]}));
    chk(12'({tSrc, tGain}), 12'({mdl.mem[23][1], mdl.mem[31][1], mdl.mem[31][2],
        mdl.mem[31][3]}));
  endtask
  // reset mid-run, refill memory, try a write during load, wait for the path
  task automatic reload(input logic [3:0] pat, input logic [1:0] mode);
    @(posedge ref_clk);
    #TDRV {rst_b, faultMode} = {1'b0, mode};
    for (int i = 0; i < 64; i++) mdl.mem[i] = 4'(i * 7 + 5) ^ pat;
    repeat (2) @(posedge ref_clk);
    #TDRV rst_b = 1;
    wr(6'h07, {4'h0, ~mdl.mem[7]});
    n = 0;
    while (pathEnable !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #TDRV n++;
    end
    chk(12'(n > 30 && n <= 36), 12'h001);
    check_all();
  endtask
  task automatic end_of_test();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ====================================================================
  // sequence of tests
  initial begin
    {rst_b, progWrEn, progWrAddr, progWrData, faultMode} = 18'h00000;
    repeat (16) @(posedge ref_clk);
    #TDRV chk({2'h0, clampLow}, 12'h028);
    chk({2'h0, clampHigh}, 12'h35C);
    chk(12'(pathEnable), 12'h000);
    reload(4'h0, 2'h0);
    chk(12'({parityErr, voteMismatch}), 12'h000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk(fieldOf(rows[i].sel), rows[i].x);
    end
    wr(6'h27, 8'h01);
    chk(12'(inputSwap), 12'h000);
    wr(6'h07, 8'h21);
    chk(12'(inputSwap), 12'h000);
    wr(6'h0E, 8'h0F);
    chk(12'(gainZero), {4'h3, mdl.mem[13], mdl.mem[12]});
    wr(6'h1E, 8'h0C);
    chk(12'(offZero), {4'h0, mdl.mem[29], mdl.mem[28]});
    reload(4'hF, 2'h1);
    chk(12'({parityErr, voteMismatch}), 12'h001);
    reload(4'h0, 2'h2);
    chk(12'(parityErr), 12'h001);
    end_of_test();
  end
  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
